/* spip_top.sv */
/*
  process image framer and parameter handshake of a profile sensor,
  with AXI4-Lite registers, explicit byte access and one irq line.
  assumes controller image and sensor data synchronous to aclk.
*/
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "spip_map.svh"
module spip_top
  import spip_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spip_meas_s meas_i,
  input wire spip_plc_s plc_i,
  input wire logic sync_in_i,
  input wire logic cyc_start_i,
  output logic laser_on_q,
  output logic meas_trig_q,
  output logic [7:0] pstat_q,
  output logic [31:0] result_q,
  output logic [5:0] setup_q,
  output logic [7:0] tx_data_q,
  output logic tx_valid_q,
  output logic tx_last_q,
  input wire logic tx_ready_i,
  output logic irq_q
);
  // ********************************
  // bus slave state
  // ********************************
  logic [7:0] aw_addr_q; // latched write address
  logic [31:0] w_data_q; // latched write data
  logic [3:0] w_strb_q;
  logic wr_go; // both halves present, apply once
  logic [31:0] wmask; // byte lanes as bit mask
  logic [31:0] rd_mux;
  logic rd_hit;
  logic wr_hit;
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  // ready flags double as empty slots; reset high is legal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2; // unmapped gets slverr
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // read: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ********************************
  // software registers
  // ********************************
  logic trig_src_q; // 0 sync input, 1 control bit
  logic [1:0] conn_q; // connection 0..3 = assembly 100..103
  logic [3:0] ists_q; // sticky events
  logic [3:0] imsk_q;
  logic [5:0] xidx_q; // explicit access byte index
  logic [31:0] ctrl_nx;
  logic [3:0] evt; // done, error, trigger, frame sent
  logic [3:0] iclr;
  logic wr_ctrl;
  logic wr_send;
  logic [7:0] xbyte; // explicit byte
  logic [7:0] in_inst;
  logic [7:0] out_inst;
  assign wr_ctrl = wr_go && (aw_addr_q == `SPIP_A_CTRL);
  assign wr_send = wr_go && (aw_addr_q == `SPIP_A_SEND) && w_strb_q[0] && w_data_q[0];
  assign iclr = (wr_go && (aw_addr_q == `SPIP_A_ISTS) && w_strb_q[0]) ? w_data_q[3:0] : 4'h0;
  assign ctrl_nx = (w_data_q & wmask) | ({22'h0, conn_q, 7'h0, trig_src_q} & ~wmask);
  assign wr_hit = (aw_addr_q == `SPIP_A_CTRL) || (aw_addr_q == `SPIP_A_STAT) ||
                  (aw_addr_q == `SPIP_A_ISTS) || (aw_addr_q == `SPIP_A_IMSK) ||
                  (aw_addr_q == `SPIP_A_XIDX) || (aw_addr_q == `SPIP_A_XDAT) ||
                  (aw_addr_q == `SPIP_A_SEND);
  assign rd_hit = (s_axi_araddr == `SPIP_A_CTRL) || (s_axi_araddr == `SPIP_A_STAT) ||
                  (s_axi_araddr == `SPIP_A_ISTS) || (s_axi_araddr == `SPIP_A_IMSK) ||
                  (s_axi_araddr == `SPIP_A_XIDX) || (s_axi_araddr == `SPIP_A_XDAT) ||
                  (s_axi_araddr == `SPIP_A_SEND);
  // instance numbers of the chosen connection
  assign in_inst = (conn_q == 2'd0) ? `SPIP_IN_100 : (conn_q == 2'd1) ? `SPIP_IN_101 :
                   (conn_q == 2'd2) ? `SPIP_IN_102 : `SPIP_IN_103;
  assign out_inst = conn_q[0] ? `SPIP_OUT_PAR : `SPIP_OUT_HB;
  assign rd_mux = (s_axi_araddr == `SPIP_A_CTRL) ? {22'h0, conn_q, 7'h0, trig_src_q} :
                  (s_axi_araddr == `SPIP_A_STAT) ? {in_inst, out_inst, 4'h0, laser_on_q, pstat_q[2:0], 2'h0, setup_q} :
                  (s_axi_araddr == `SPIP_A_ISTS) ? {28'h0, ists_q} :
                  (s_axi_araddr == `SPIP_A_IMSK) ? {28'h0, imsk_q} :
                  (s_axi_araddr == `SPIP_A_XIDX) ? {26'h0, xidx_q} :
                  (s_axi_araddr == `SPIP_A_XDAT) ? {24'h0, xbyte} : 32'h0;
  // register writes honour byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_src_q <= 1'b0;
      conn_q <= 2'd0;
      imsk_q <= 4'h0;
      xidx_q <= 6'd0;
    end else if (wr_go) begin
      if (wr_ctrl) begin
        trig_src_q <= ctrl_nx[`SPIP_CTRL_TSRC];
        conn_q <= ctrl_nx[`SPIP_CTRL_CONN +: 2];
      end
      if (aw_addr_q == `SPIP_A_IMSK && w_strb_q[0]) begin
        imsk_q <= w_data_q[3:0];
      end
      if (aw_addr_q == `SPIP_A_XIDX && w_strb_q[0]) begin
        xidx_q <= w_data_q[5:0];
      end
    end
  end
  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ists_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      ists_q <= (ists_q & ~iclr) | evt;
      irq_q <= |(((ists_q & ~iclr) | evt) & imsk_q);
    end
  end
  // ********************************
  // laser and trigger
  // ********************************
  logic trig_src_w; // selected trigger source level
  logic src_prev_q;
  logic [1:0] sens_echo_q; // sensor control in byte
  logic trig_evt;
  assign trig_src_w = trig_src_q ? plc_i.sens_ctrl[`SPIP_TRIG_BIT] : sync_in_i;
  // no laser, no measurement: trigger suppressed
  assign trig_evt = trig_src_w && !src_prev_q && laser_on_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      laser_on_q <= 1'b0;
      meas_trig_q <= 1'b0;
      src_prev_q <= 1'b0;
      sens_echo_q <= 2'h0;
    end else begin
      laser_on_q <= plc_i.sens_ctrl[`SPIP_LASER_BIT];
      src_prev_q <= trig_src_w;
      meas_trig_q <= trig_evt;
      sens_echo_q <= plc_i.sens_ctrl[1:0];
    end
  end
  // ********************************
  // parameter access handshake
  // ********************************
  spip_pst_e st_q;
  spip_pst_e st_d;
  logic req_w; // request bit from controller
  logic take; // request accepted this cycle
  logic rq_wr_q; // captured write flag
  logic [15:0] rq_func_q;
  logic [31:0] rq_val_q;
  logic func_ok;
  logic rng_ok;
  logic pm_ok;
  logic acc_ok;
  logic [31:0] err_code;
  assign req_w = plc_i.param_ctrl[`SPIP_REQ_BIT];
  assign take = (st_q == PST_IDLE) && req_w;
  assign func_ok = (rq_func_q == `SPIP_FUNC_SETUP);
  assign rng_ok = (rq_val_q[7:0] >= `SPIP_SETUP_MIN) && (rq_val_q[7:0] <= `SPIP_SETUP_MAX);
  assign pm_ok = (meas_i.param_mode != 8'h00);
  assign acc_ok = func_ok && (!rq_wr_q || (rng_ok && pm_ok));
  assign err_code = !func_ok ? `SPIP_ERR_FUNC : !rng_ok ? `SPIP_ERR_RANGE : `SPIP_ERR_MODE;
  assign evt[0] = (st_q == PST_BUSY) && acc_ok;
  assign evt[1] = (st_q == PST_BUSY) && !acc_ok;
  assign evt[2] = trig_evt;
  // next state; done and error stay until request drops
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      PST_IDLE: if (req_w) st_d = PST_BUSY;
      PST_BUSY: st_d = acc_ok ? PST_DONE : PST_ERR;
      PST_DONE: if (!req_w) st_d = PST_IDLE;
      PST_ERR: if (!req_w) st_d = PST_IDLE;
      default: st_d = PST_IDLE; // illegal code recovers
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= PST_IDLE;
      pstat_q <= 8'h00;
    end else begin
      st_q <= st_d;
      pstat_q <= {5'h00, st_d == PST_ERR, st_d == PST_BUSY, st_d == PST_DONE};
    end
  end
  // capture the request so the controller may change it while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rq_wr_q <= 1'b0;
      rq_func_q <= 16'h0000;
      rq_val_q <= 32'h0;
    end else if (take) begin
      rq_wr_q <= plc_i.param_ctrl[`SPIP_WR_BIT];
      rq_func_q <= plc_i.param_function_select;
      rq_val_q <= plc_i.param_value;
    end
  end
  // result and active setup update at end of busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= 32'h0;
      setup_q <= `SPIP_SETUP_RST;
    end else if (st_q == PST_BUSY) begin
      if (!acc_ok) begin
        result_q <= err_code;
      end else if (rq_wr_q) begin
        result_q <= {24'h0, rq_val_q[7:0]};
        setup_q <= rq_val_q[5:0];
      end else begin
        result_q <= {26'h0, setup_q};
      end
    end
  end
  // ********************************
  // cyclic frame and explicit access
  // ********************************
  logic act_q; // frame in progress
  logic [5:0] idx_q; // index of byte on tx_data_q
  logic [1:0] frm_inst_q; // connection frozen for the frame
  logic start;
  logic adv;
  logic [5:0] nidx;
  logic [1:0] ninst;
  logic [7:0] sbyte;
  logic [5:0] slen;
  assign start = !act_q && (cyc_start_i || wr_send); // ignored while a frame runs
  assign adv = tx_valid_q && tx_ready_i && !tx_last_q;
  assign nidx = start ? 6'd0 : idx_q + 6'd1;
  assign ninst = start ? conn_q : frm_inst_q;
  assign evt[3] = tx_valid_q && tx_ready_i && tx_last_q;
  spip_asm u_cyc (
    .meas_i(meas_i),
    .sens_i({6'h00, sens_echo_q}),
    .pstat_i(pstat_q),
    .pval_i(result_q),
    .inst_i(ninst),
    .idx_i(nidx),
    .byte_o(sbyte),
    .len_o(slen)
  );
  spip_asm u_expl (
    .meas_i(meas_i),
    .sens_i({6'h00, sens_echo_q}),
    .pstat_i(pstat_q),
    .pval_i(result_q),
    .inst_i(conn_q),
    .idx_i(xidx_q),
    .byte_o(xbyte),
    .len_o()
  );
  // byte stream; valid holds until tx_ready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 1'b0;
      idx_q <= 6'd0;
      frm_inst_q <= 2'd0;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else if (start || adv) begin
      act_q <= 1'b1;
      idx_q <= nidx;
      frm_inst_q <= ninst;
      tx_valid_q <= 1'b1;
      tx_data_q <= sbyte;
      tx_last_q <= (nidx == slen - 6'd1);
    end else if (evt[3]) begin
      act_q <= 1'b0;
      tx_valid_q <= 1'b0;
      tx_last_q <= 1'b0;
    end
  end
  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_trig;
    $rose(trig_src_w) && laser_on_q |=> meas_trig_q;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger edge lost");
  property p_laser;
    meas_trig_q |-> $past(laser_on_q);
  endproperty
  a_laser: assert property (p_laser) else $error("trigger without laser");
  property p_stat;
    pstat_q[7:3] == 5'h00 && $onehot0(pstat_q[2:0]);
  endproperty
  a_stat: assert property (p_stat) else $error("bad status byte");
  property p_rdres;
    $rose(pstat_q[0]) && !rq_wr_q |-> result_q == {26'h0, setup_q};
  endproperty
  a_rdres: assert property (p_rdres) else $error("read result wrong");
  property p_setup;
    setup_q >= 6'd1 && setup_q <= 6'd32;
  endproperty
  a_setup: assert property (p_setup) else $error("setup out of range");
  property p_pmode;
    $changed(setup_q) |-> $past(meas_i.param_mode) != 8'h00 && pstat_q[0];
  endproperty
  a_pmode: assert property (p_pmode) else $error("setup changed outside mode");
  property p_busy;
    pstat_q == 8'h00 && req_w |=> pstat_q[1] ##1 (pstat_q[0] || pstat_q[2]);
  endproperty
  a_busy: assert property (p_busy) else $error("busy sequence wrong");
  property p_clr;
    (pstat_q[0] || pstat_q[2]) && !req_w |=> pstat_q == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("done or error not cleared");
  property p_len100;
    evt[3] && frm_inst_q == 2'd0 |-> idx_q == 6'd49;
  endproperty
  a_len100: assert property (p_len100) else $error("frame 100 length");
  property p_len101;
    evt[3] && frm_inst_q == 2'd1 |-> idx_q == 6'd55;
  endproperty
  a_len101: assert property (p_len101) else $error("frame 101 length");
  property p_len102;
    evt[3] && frm_inst_q == 2'd2 |-> idx_q == 6'd33;
  endproperty
  a_len102: assert property (p_len102) else $error("frame 102 length");
  property p_len103;
    evt[3] && frm_inst_q == 2'd3 |-> idx_q == 6'd39;
  endproperty
  a_len103: assert property (p_len103) else $error("frame 103 length");
  property p_first;
    start |=> tx_valid_q && idx_q == 6'd0 && tx_data_q == $past(meas_i.param_mode);
  endproperty
  a_first: assert property (p_first) else $error("first byte wrong");
  property p_xdat;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `SPIP_A_XDAT |=> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_xdat: assert property (p_xdat) else $error("explicit byte too wide");
  c_wdone: cover property (evt[0] && rq_wr_q);
  c_err: cover property (evt[1]);
  c_frame: cover property (evt[3] && frm_inst_q == 2'd1);
  c_trig: cover property (meas_trig_q && trig_src_q);
endmodule : spip_top

/* spip_map.svh */
/*
  address map, field positions, reset values and fixed sizes of the
  sensor process image and parameter access block.
  assumes byte addresses on the AXI4-Lite bus, low 8 bits decoded.
*/
`ifndef SPIP_MAP_SVH
`define SPIP_MAP_SVH
// ********************************
// register byte offsets
// ********************************
`define SPIP_A_CTRL 8'h00
`define SPIP_A_STAT 8'h04
`define SPIP_A_ISTS 8'h08
`define SPIP_A_IMSK 8'h0C
`define SPIP_A_XIDX 8'h10
`define SPIP_A_XDAT 8'h14
`define SPIP_A_SEND 8'h18
// ********************************
// field positions
// ********************************
`define SPIP_CTRL_TSRC 0
`define SPIP_CTRL_CONN 8
`define SPIP_REQ_BIT 0
`define SPIP_WR_BIT 1
`define SPIP_LASER_BIT 0
`define SPIP_TRIG_BIT 1
// ********************************
// reset values and codes
// ********************************
`define SPIP_SETUP_RST 6'd1
`define SPIP_SETUP_MIN 8'd1
`define SPIP_SETUP_MAX 8'd32
`define SPIP_FUNC_SETUP 16'h0000
`define SPIP_ERR_FUNC 32'h00000001
`define SPIP_ERR_RANGE 32'h00000002
`define SPIP_ERR_MODE 32'h00000003
// ********************************
// connection sizes and instances
// ********************************
`define SPIP_IN_100 8'd100
`define SPIP_IN_101 8'd101
`define SPIP_IN_102 8'd102
`define SPIP_IN_103 8'd103
`define SPIP_OUT_HB 8'd238
`define SPIP_OUT_PAR 8'd110
`define SPIP_LEN_100 6'd50
`define SPIP_LEN_101 6'd56
`define SPIP_LEN_102 6'd34
`define SPIP_LEN_103 6'd40
`define SPIP_O2T_LEN 6'd8
`define SPIP_O2T_HDR 6'd4
`endif

/* spip_pkg.sv */
/*
  types of the sensor process image block.
  assumes spip_map.svh for all numeric constants except the one-hot state codes.
*/
package spip_pkg;
  // sensor side measurement data, one snapshot
  typedef struct packed {
    logic [7:0] param_mode;
    logic [7:0] time_sync;
    logic [7:0] valid_vals;
    logic [7:0] alarm;
    logic [7:0] quality;
    logic [7:0] out1;
    logic [7:0] out2;
    logic [6:0][31:0] fval;
    logic [31:0] rate_f;
    logic [31:0] ts_s;
    logic [31:0] ts_us;
    logic [15:0] enc;
    logic [6:0][15:0] ival;
    logic [15:0] rate_i;
  } spip_meas_s;
  // controller output image, header already stripped
  typedef struct packed {
    logic [7:0] sens_ctrl;
    logic [7:0] param_ctrl;
    logic [15:0] param_function_select;
    logic [31:0] param_value;
  } spip_plc_s;
  // parameter access states
  typedef enum logic [3:0] {
    PST_IDLE = 4'b0001,
    PST_BUSY = 4'b0010,
    PST_DONE = 4'b0100,
    PST_ERR = 4'b1000
  } spip_pst_e;
endpackage : spip_pkg

/* spip_asm.sv */
/*
  byte picker for the four input assemblies.
  assumes little-endian multi-byte fields; purely combinational.
*/
`timescale 1ns/10ps
`include "spip_map.svh"
module spip_asm
  import spip_pkg::*;
(
  input wire spip_meas_s meas_i,
  input wire logic [7:0] sens_i,
  input wire logic [7:0] pstat_i,
  input wire logic [31:0] pval_i,
  input wire logic [1:0] inst_i,
  input wire logic [5:0] idx_i,
  output logic [7:0] byte_o,
  output logic [5:0] len_o
);
  // ********************************
  // image build
  // ********************************
  logic [447:0] img_f; // float layout, 56 bytes
  logic [319:0] img_i; // integer layout, 40 bytes
  logic [447:0] sh_f;
  logic [319:0] sh_i;
  logic [55:0] head; // seven status bytes, byte 0 lowest
  assign head = {meas_i.out2, meas_i.out1, meas_i.quality, meas_i.alarm,
                 meas_i.valid_vals, meas_i.time_sync, meas_i.param_mode};
  assign img_f[63:0] = {8'h00, head};
  assign img_i[63:0] = {8'h00, head};
  // seven measured values per layout
  for (genvar g = 0; g < 7; g++) begin : g_val
    assign img_f[64+32*g +: 32] = meas_i.fval[g];
    assign img_i[64+16*g +: 16] = meas_i.ival[g];
  end
  assign img_f[447:288] = {pval_i, pstat_i, sens_i, meas_i.enc, meas_i.ts_us, meas_i.ts_s, meas_i.rate_f};
  assign img_i[319:176] = {pval_i, pstat_i, sens_i, meas_i.enc, meas_i.ts_us, meas_i.ts_s, meas_i.rate_i};
  // ********************************
  // selection
  // ********************************
  assign sh_f = img_f >> {idx_i, 3'h0};
  assign sh_i = img_i >> {idx_i, 3'h0};
  // length per connection; bytes past it read zero
  assign len_o = (inst_i == 2'd0) ? `SPIP_LEN_100 :
                 (inst_i == 2'd1) ? `SPIP_LEN_101 :
                 (inst_i == 2'd2) ? `SPIP_LEN_102 : `SPIP_LEN_103;
  assign byte_o = (idx_i >= len_o) ? 8'h00 : (inst_i[1] ? sh_i[7:0] : sh_f[7:0]);
endmodule : spip_asm

/* spip_plc_model.sv */
/*
  controller model: drives the output image toward the sensor block.
  assumes pstat_i comes from the block and all logic runs on aclk.
*/
`timescale 1ns/10ps
module spip_plc_model
  import spip_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic [15:0] sel_i,
  input wire logic [31:0] val_i,
  input wire logic laser_i,
  input wire logic trig_i,
  input wire logic [7:0] pstat_i,
  output spip_plc_s plc_o
);
  // ********************************
  // request handshake
  // ********************************
  logic req_q; // request bit
  logic wr_q; // write or read
  logic [15:0] sel_q; // selector
  logic [31:0] val_q; // new value
  // start only when idle, hold until done or error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_q <= 1'b0;
      wr_q <= 1'b0;
      sel_q <= 16'h0000;
      val_q <= 32'h00000000;
    end else if (go_i && pstat_i == 8'h00) begin
      req_q <= 1'b1;
      wr_q <= wr_i;
      sel_q <= sel_i;
      val_q <= val_i;
    end else if (pstat_i[0] || pstat_i[2]) begin
      req_q <= 1'b0;
    end
  end
  // value shown inverted outside a request, so stale data is never trusted
  assign plc_o = {6'h00, trig_i, laser_i, 6'h00, wr_q, req_q, sel_q, req_q ? val_q : ~val_q};
endmodule : spip_plc_model

/* tb_top.sv */
/*
  self-checking bench of the sensor process image block.
  assumes spip_pkg, spip_map.svh and the controller model compiled first.
*/
`timescale 1ns/10ps
`include "spip_map.svh"
module tb_top
  import spip_pkg::*;
;
  // ********************************
  // signals
  // ********************************
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, result_q, rd, rnd = 32'h9C6BE319;
  spip_meas_s meas = '0;
  spip_plc_s plc;
  logic sync_in = 1'b0, cyc = 1'b0, tx_ready = 1'b0, go = 1'b0, wr = 1'b0, laser = 1'b0, trig = 1'b0;
  logic [15:0] sel = 16'h0000;
  logic [31:0] val = 32'h00000000;
  logic laser_on_q, meas_trig_q, tx_valid_q, tx_last_q, irq_q;
  logic [7:0] pstat_q, tx_data_q;
  logic [5:0] setup_q;
  logic [1:0] rs;
  int miscompares = 0, comparisons = 0, n, cnt, k;
  logic [543:0] mw;
  initial forever #5 aclk = ~aclk;
  spip_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(rready), .meas_i(meas), .plc_i(plc),
    .sync_in_i(sync_in), .cyc_start_i(cyc), .laser_on_q(laser_on_q), .meas_trig_q(meas_trig_q),
    .pstat_q(pstat_q), .result_q(result_q), .setup_q(setup_q), .tx_data_q(tx_data_q), .tx_valid_q(tx_valid_q),
    .tx_last_q(tx_last_q), .tx_ready_i(tx_ready), .irq_q(irq_q));
  spip_plc_model plc_m (.aclk(aclk), .aresetn(aresetn), .go_i(go), .wr_i(wr), .sel_i(sel), .val_i(val),
    .laser_i(laser), .trig_i(trig), .pstat_i(pstat_q), .plc_o(plc));
  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // expected byte of the float input assembly, little-endian fields
  function automatic logic [7:0] exp100(input spip_meas_s m, input int i);
    logic [7:0] hd [7];
    logic [31:0] w;
    hd = '{m.param_mode, m.time_sync, m.valid_vals, m.alarm, m.quality, m.out1, m.out2};
    if (i < 7) return hd[i];
    if (i == 7) return 8'h00;
    if (i < 36) w = m.fval[(i - 8) / 4];
    else if (i < 40) w = m.rate_f;
    else if (i < 44) w = m.ts_s;
    else if (i < 48) w = m.ts_us;
    else w = {16'h0000, m.enc};
    return w[8 * ((i - 8) % 4) +: 8];
  endfunction : exp100
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // a spent wait bound is a mismatch and ends the run
  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      miscompares++;
      stop_test();
    end
  endtask : tmo
  // ready sampled at the falling edge, released after the rising edge that took it
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, bv;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      {ta, tw, bv, r} = {awvalid & s_axi_awready, wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (bv) break;
    end
    bready <= 1'b0;
    tmo(n, 50);
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, rv;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      {ta, rv, d, r} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (rv) break;
    end
    rready <= 1'b0;
    tmo(n, 50);
  endtask : axr
  // one parameter access through the controller model
  task automatic par(input logic w, input logic [15:0] s, input logic [31:0] v, input logic [7:0] es,
                     input logic [31:0] er);
    logic [7:0] first;
    first = 8'h00;
    @(posedge aclk);
    {go, wr, sel, val} <= {1'b1, w, s, v};
    @(posedge aclk);
    go <= 1'b0;
    for (n = 0; n < 20 && !(pstat_q[0] || pstat_q[2]); n++) begin
      @(negedge aclk);
      if (first == 8'h00) first = pstat_q;
    end
    tmo(n, 20);
    chk("busy", first, 8'h02);
    chk("pstat", pstat_q, es);
    chk("result", result_q, er);
    for (n = 0; n < 20 && pstat_q !== 8'h00; n++) @(negedge aclk);
    tmo(n, 20);
  endtask : par
  task automatic trg(input logic [31:0] e);
    cnt = 0;
    for (k = 0; k < 8; k++) begin
      @(negedge aclk);
      cnt += meas_trig_q;
    end
    chk("trig", cnt, e);
    @(posedge aclk);
  endtask : trg
  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (16) @(posedge aclk);
    for (k = 0; k < 544; k += 32) begin
      rnd = nxt(rnd);
      mw[k +: 32] = rnd;
    end
    aresetn <= 1'b1;
    meas <= mw[519:0];
    laser <= 1'b1;
    axr(`SPIP_A_STAT, rd, rs);
    chk("stat_rst", rd, 32'h64EE0801);
    axr(8'h40, rd, rs);
    chk("unmapped_rd", rd, 32'h0);
    chk("unmapped_rresp", rs, 2'b10);
    axw(8'h40, 32'h1, rs);
    chk("unmapped_wr", rs, 2'b10);
    for (int c = 0; c < 4; c++) begin
      axw(`SPIP_A_CTRL, c << 8, rs);
      axr(`SPIP_A_STAT, rd, rs);
      chk("inst", rd[31:16], {8'(100 + c), c[0] ? 8'd110 : 8'd238});
      axw(`SPIP_A_XIDX, c[0] ? (c[1] ? 40 : 56) : (c[1] ? 34 : 50), rs);
      axr(`SPIP_A_XDAT, rd, rs);
      chk("past_len", rd, 32'h0);
    end
    axw(`SPIP_A_CTRL, 32'h0, rs);
    axw(`SPIP_A_XIDX, rnd % 50, rs);
    axr(`SPIP_A_XDAT, rd, rs);
    chk("xdat", rd, exp100(meas, rnd % 50));
    $display("test registers done");
    meas.param_mode <= 8'h01;
    cnt = (nxt(rnd) % 32) + 1;
    par(1'b1, `SPIP_FUNC_SETUP, cnt, 8'h01, cnt);
    chk("setup", setup_q, cnt);
    par(1'b0, 16'h0000, 32'h0, 8'h01, cnt);
    par(1'b1, 16'h0000, 32'h0, 8'h04, 32'h2);
    par(1'b1, 16'h0000, 32'h21, 8'h04, 32'h2);
    par(1'b1, 16'h0001, 32'h5, 8'h04, 32'h1);
    meas.param_mode <= 8'h00;
    par(1'b1, 16'h0000, 32'h20, 8'h04, 32'h3);
    chk("setup_kept", setup_q, cnt);
    chk("irq_masked", irq_q, 1'b0);
    axw(`SPIP_A_IMSK, 32'h3, rs);
    repeat (2) @(posedge aclk);
    chk("irq_on", irq_q, 1'b1);
    axw(`SPIP_A_ISTS, 32'hF, rs);
    repeat (2) @(posedge aclk);
    chk("irq_off", irq_q, 1'b0);
    $display("test parameter done");
    axw(`SPIP_A_CTRL, 32'h1, rs);
    chk("laser", laser_on_q, 1'b1);
    trig <= 1'b1;
    trg(1);
    {laser, trig} <= 2'b00;
    repeat (2) @(posedge aclk);
    trig <= 1'b1;
    trg(0);
    {laser, trig} <= 2'b10;
    axw(`SPIP_A_CTRL, 32'h0, rs);
    sync_in <= 1'b1;
    trg(1);
    $display("test trigger done");
    @(posedge aclk);
    cyc <= 1'b1;
    @(posedge aclk);
    cyc <= 1'b0;
    cnt = 0;
    for (n = 0; n < 500 && cnt < 50; n++) begin
      @(negedge aclk);
      if (tx_valid_q && tx_ready) begin
        chk("byte", tx_data_q, exp100(meas, cnt));
        chk("last", tx_last_q, cnt == 49);
        cnt++;
      end
      @(posedge aclk);
      rnd = nxt(rnd);
      tx_ready <= rnd[0] | rnd[1];
    end
    tmo(n, 500);
    repeat (3) @(posedge aclk);
    chk("frame_end", tx_valid_q, 1'b0);
    axw(`SPIP_A_SEND, 32'h1, rs);
    chk("send_start", tx_valid_q, 1'b1);
    $display("test stream done");
    stop_test();
  end
endmodule : tb_top
